/* rtl/cvi_pkg.sv */
// Constants, carrier types and defaults for the command value input stage.
// Assumes one clock domain and an AXI4-Lite master that holds the register map below.
package cvi_pkg;

  localparam int DW = 24;
  localparam int W2 = 2 * DW + 2;

  typedef enum logic [2:0] {
    SIG_VOLT = 3'b000, SIG_CURR = 3'b001, SIG_DIG = 3'b010, SIG_FREQ = 3'b011, SIG_PWM = 3'b100
  } cvi_sig_t;

  typedef enum logic [2:0] {
    MRG_NONE = 3'b000, MRG_ADD = 3'b001, MRG_MUL = 3'b010, MRG_ALT = 3'b011, MRG_SPD = 3'b100
  } cvi_mrg_t;

  // Config word: bit 0 bus source, 3:1 type, 6:4 analog sel, 9:7 digital sel, 10 break check.
  typedef struct packed {
    logic cb_en;
    logic [2:0] dig_sel;
    logic [2:0] ana_sel;
    cvi_sig_t sig;
    logic src_bus;
  } cvi_cfg_t;

  typedef struct packed {
    logic [DW-1:0] lo;
    logic [DW-1:0] hi;
    logic [DW-1:0] ifmin;
    logic [DW-1:0] ifmax;
    logic [DW-1:0] rmin;
    logic [DW-1:0] rmax;
  } cvi_lim_t;

  localparam int CFG_W = 11;
  localparam int MRG_FUNC_LSB = 0;
  localparam int MRG_ALT_LSB = 4;
  localparam int MODE_BIPOLAR = 0;
  localparam int MODE_THREE = 1;

  // Per-channel block: command 1 at 0x00, command 2 at 0x20.
  localparam logic [4:0] OFS_CFG = 5'h00;
  localparam logic [4:0] OFS_LO = 5'h04;
  localparam logic [4:0] OFS_HI = 5'h08;
  localparam logic [4:0] OFS_IFMIN = 5'h0C;
  localparam logic [4:0] OFS_IFMAX = 5'h10;
  localparam logic [4:0] OFS_RMIN = 5'h14;
  localparam logic [4:0] OFS_RMAX = 5'h18;
  localparam logic [4:0] OFS_VALUE = 5'h1C;
  localparam logic [7:0] ADR_MERGE = 8'h40;
  localparam logic [7:0] ADR_MODE = 8'h44;
  localparam logic [7:0] ADR_SPD_POS = 8'h48;
  localparam logic [7:0] ADR_SPD_NEG = 8'h4C;
  localparam logic [7:0] ADR_STATUS = 8'h50;
  localparam logic [7:0] ADR_MASK = 8'h54;
  localparam logic [7:0] ADR_RESULT = 8'h58;
  localparam logic [7:0] ADR_RAMP = 8'h5C;

  // Units: mV, uA, 0.1 Hz, 0.1 %PW; references in 0.01 mm.
  localparam logic [DW-1:0] RST_REF_MIN = 24'h000000;
  localparam logic [DW-1:0] RST_REF_MAX = 24'h002710;
  localparam logic [DW-1:0] RST_SPD = 24'h0003E8;
  localparam logic [DW-1:0] FULL_SCALE = 24'h002710;

  function automatic cvi_lim_t cvi_defaults(input cvi_sig_t s);
    cvi_lim_t l;
    l.rmin = RST_REF_MIN;
    l.rmax = RST_REF_MAX;
    unique case (s)
      SIG_VOLT: {l.lo, l.hi, l.ifmin, l.ifmax} = {24'h0001F4, 24'h002710, 24'h000000, 24'h002710};
      SIG_CURR: {l.lo, l.hi, l.ifmin, l.ifmax} = {24'h0001F4, 24'h004E20, 24'h000000, 24'h004E20};
      SIG_FREQ: {l.lo, l.hi, l.ifmin, l.ifmax} = {24'h000064, 24'h00C350, 24'h000032, 24'h00C350};
      SIG_PWM: {l.lo, l.hi, l.ifmin, l.ifmax} = {24'h000064, 24'h0003E8, 24'h000032, 24'h0003B6};
      default: {l.lo, l.hi, l.ifmin, l.ifmax} = {24'h000000, 24'h000001, 24'h000000, 24'h000001};
    endcase
    return l;
  endfunction

endpackage

/* rtl/cvi_top.sv */
// Command value input stage: two scaled command inputs, merge, cable break, AXI4-Lite regs.
// Assumes analog samples, measured frequency/PWM values and fieldbus values arrive on
// core_clk; only the raw digital input pins are asynchronous.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
module cvi_top
  import cvi_pkg::*;
#(
  parameter int NAI = 4,
  parameter int NDI = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NAI-1:0][DW-1:0] ana_in,
  input wire logic [NDI-1:0][DW-1:0] meas_in,
  input wire logic [NDI-1:0] dig_pin,
  input wire logic [1:0][DW-1:0] bus_cmd,
  output logic [DW-1:0] cmd_out,
  output logic [DW-1:0] ramp_speed,
  output logic speed_mode,
  output logic [1:0] cbrk,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Digital pin synchroniser and filter.

  logic [NDI-1:0] dsync1_ff, dsync2_ff, dsync3_ff, dig_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dsync1_ff <= '0;
      dsync2_ff <= '0;
      dsync3_ff <= '0;
    end else begin
      dsync1_ff <= dig_pin;
      dsync2_ff <= dsync1_ff;
      dsync3_ff <= dsync2_ff;
    end
  end

  // A level is accepted only once two successive samples agree.
  genvar gi;
  generate
    for (gi = 0; gi < NDI; gi++) begin : g_dig
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          dig_ff[gi] <= 1'b0;
        end else if (dsync2_ff[gi] == dsync3_ff[gi]) begin
          dig_ff[gi] <= dsync3_ff[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshake.

  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wr_fire;

  // Ready is low while a captured address or data word waits to be applied.
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  function automatic logic mapped(input logic [7:0] a);
    return (a[7:6] == 2'b00 && a[1:0] == 2'b00) ||
           (a[7:5] == 3'b010 && a[1:0] == 2'b00);
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(awaddr_ff) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  cvi_cfg_t cfg_ff [2];
  cvi_lim_t lim_ff [2];
  logic [2:0] merge_ff;
  logic [2:0] alt_sel_ff;
  logic [1:0] mode_ff;
  logic [DW-1:0] spd_pos_ff, spd_neg_ff;
  logic [1:0] mask_ff, status_ff;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_chreg
      logic hit;
      logic [31:0] wv, old_w;
      cvi_cfg_t nxt_cfg;
      assign hit = wr_fire && awaddr_ff[7:6] == 2'b00 && awaddr_ff[5] == 1'(gi);
      always_comb begin
        // Strobes merge into the word being written; the value offset is read-only.
        old_w = (awaddr_ff[4:0] == OFS_CFG) ? {{(32-CFG_W){1'b0}}, cfg_ff[gi]} :
                sx(lim_ff[gi][(6 - int'(awaddr_ff[4:2])) * DW +: DW]);
        wv = strb_merge(old_w, wdata_ff, wstrb_ff);
        nxt_cfg = cvi_cfg_t'(wv[CFG_W-1:0]);
        if (mode_ff[MODE_BIPOLAR] && nxt_cfg.sig != SIG_VOLT) begin
          nxt_cfg.sig = cfg_ff[gi].sig;
        end
        if (nxt_cfg.sig > SIG_PWM) begin
          nxt_cfg.sig = cfg_ff[gi].sig;
        end
      end
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          cfg_ff[gi] <= '0;
          lim_ff[gi] <= cvi_defaults(SIG_VOLT);
        end else if (hit) begin
          unique case (awaddr_ff[4:0])
            OFS_CFG: begin
              cfg_ff[gi] <= nxt_cfg;
              if (nxt_cfg.sig != cfg_ff[gi].sig) begin
                lim_ff[gi] <= cvi_defaults(nxt_cfg.sig);
              end
            end
            OFS_LO: lim_ff[gi].lo <= wv[DW-1:0];
            OFS_HI: lim_ff[gi].hi <= wv[DW-1:0];
            OFS_IFMIN: lim_ff[gi].ifmin <= wv[DW-1:0];
            OFS_IFMAX: lim_ff[gi].ifmax <= wv[DW-1:0];
            OFS_RMIN: lim_ff[gi].rmin <= wv[DW-1:0];
            OFS_RMAX: lim_ff[gi].rmax <= wv[DW-1:0];
            default: ;
          endcase
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      merge_ff <= MRG_NONE;
      alt_sel_ff <= '0;
      mode_ff <= '0;
      spd_pos_ff <= RST_SPD;
      spd_neg_ff <= RST_SPD;
      mask_ff <= '0;
    end else if (wr_fire) begin
      unique case (awaddr_ff)
        ADR_MERGE: begin
          if (wdata_ff[MRG_FUNC_LSB +: 3] <= MRG_SPD) begin
            merge_ff <= wdata_ff[MRG_FUNC_LSB +: 3];
          end
          alt_sel_ff <= wdata_ff[MRG_ALT_LSB +: 3];
        end
        ADR_MODE: mode_ff <= wdata_ff[1:0];
        ADR_SPD_POS: spd_pos_ff <= wdata_ff[DW-1:0];
        ADR_SPD_NEG: spd_neg_ff <= wdata_ff[DW-1:0];
        ADR_MASK: mask_ff <= wdata_ff[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Source selection, scaling and cable break.

  function automatic logic signed [DW-1:0] scale(input logic signed [DW-1:0] x,
                                                 input cvi_lim_t l);
    logic signed [W2-1:0] num, den, q;
    num = (W2'(x) - W2'($signed(l.ifmin))) * (W2'($signed(l.rmax)) - W2'($signed(l.rmin)));
    den = W2'($signed(l.ifmax)) - W2'($signed(l.ifmin));
    q = (den == '0) ? '0 : num / den;
    return DW'(W2'($signed(l.rmin)) + q);
  endfunction

  logic cmd2_on;
  logic signed [DW-1:0] val_ff [2];
  logic [1:0] nxt_cbrk;

  assign cmd2_on = merge_ff != MRG_NONE;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      logic signed [DW-1:0] raw;
      logic dlvl;
      logic ana_type;
      always_comb begin
        raw = '0;
        dlvl = 1'b0;
        ana_type = cfg_ff[gi].sig == SIG_VOLT || cfg_ff[gi].sig == SIG_CURR;
        if (ana_type) begin
          if (cfg_ff[gi].ana_sel != 3'h0 && int'(cfg_ff[gi].ana_sel) <= NAI) begin
            raw = ana_in[cfg_ff[gi].ana_sel - 3'h1];
          end
        end else if (cfg_ff[gi].dig_sel != 3'h0 && int'(cfg_ff[gi].dig_sel) <= NDI) begin
          raw = meas_in[cfg_ff[gi].dig_sel - 3'h1];
          dlvl = dig_ff[cfg_ff[gi].dig_sel - 3'h1];
        end
        nxt_cbrk[gi] = cfg_ff[gi].cb_en && cfg_ff[gi].sig != SIG_DIG && !cfg_ff[gi].src_bus &&
                       (raw < $signed(lim_ff[gi].lo) ||
                        raw > $signed(lim_ff[gi].hi)) &&
                       (gi == 0 || cmd2_on);
      end
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          val_ff[gi] <= '0;
        end else if (gi == 1 && !cmd2_on) begin
          val_ff[gi] <= '0;
        end else if (cfg_ff[gi].src_bus) begin
          val_ff[gi] <= bus_cmd[gi];
        end else if (cfg_ff[gi].sig == SIG_DIG) begin
          val_ff[gi] <= dlvl ? lim_ff[gi].rmax : lim_ff[gi].rmin;
        end else begin
          val_ff[gi] <= scale(raw, lim_ff[gi]);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Merge of command 2 into command 1.

  logic alt_lvl;
  logic signed [W2-1:0] a_w, b_w, nxt_res, nxt_ramp;

  always_comb begin
    a_w = W2'(val_ff[0]);
    b_w = W2'(val_ff[1]);
    alt_lvl = alt_sel_ff != 3'h0 && int'(alt_sel_ff) <= NDI && dig_ff[alt_sel_ff - 3'h1];
    nxt_res = a_w;
    nxt_ramp = '0;
    unique case (merge_ff)
      MRG_NONE: nxt_res = a_w;
      MRG_ADD: nxt_res = a_w + b_w;
      MRG_MUL: begin
        if (b_w >= 0) begin
          nxt_res = a_w * b_w / W2'($signed(FULL_SCALE));
        end else begin
          nxt_res = a_w * W2'($signed(FULL_SCALE)) / (-b_w);
        end
      end
      MRG_ALT: nxt_res = alt_lvl ? b_w : a_w;
      MRG_SPD: begin
        nxt_res = a_w;
        if (b_w >= 0) begin
          nxt_ramp = W2'(spd_pos_ff) * b_w / W2'(FULL_SCALE);
        end else begin
          nxt_ramp = W2'(spd_neg_ff) * (-b_w) / W2'(FULL_SCALE);
        end
      end
      default: nxt_res = a_w;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_out <= '0;
      ramp_speed <= '0;
      speed_mode <= 1'b0;
    end else begin
      cmd_out <= DW'(nxt_res);
      ramp_speed <= DW'(nxt_ramp);
      speed_mode <= merge_ff == MRG_SPD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Cable break status and interrupt; a new break wins over a clearing write.

  logic [1:0] clr;

  assign clr = (wr_fire && awaddr_ff == ADR_STATUS) ? wdata_ff[1:0] & {2{wstrb_ff[0]}} : 2'b00;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cbrk <= '0;
      status_ff <= '0;
      irq <= 1'b0;
    end else begin
      cbrk <= nxt_cbrk;
      status_ff <= (status_ff & ~clr) | (nxt_cbrk & ~cbrk);
      irq <= |(status_ff & mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path.

  logic [31:0] rd_mux;
  logic [7:0] ra;

  function automatic logic [31:0] sx(input logic [DW-1:0] v);
    return {{(32-DW){v[DW-1]}}, v};
  endfunction

  always_comb begin
    ra = s_axi_araddr;
    rd_mux = '0;
    if (ra[7:6] == 2'b00) begin
      unique case (ra[4:0])
        OFS_CFG: rd_mux = {{(32-CFG_W){1'b0}}, cfg_ff[ra[5]]};
        OFS_LO: rd_mux = sx(lim_ff[ra[5]].lo);
        OFS_HI: rd_mux = sx(lim_ff[ra[5]].hi);
        OFS_IFMIN: rd_mux = sx(lim_ff[ra[5]].ifmin);
        OFS_IFMAX: rd_mux = sx(lim_ff[ra[5]].ifmax);
        OFS_RMIN: rd_mux = sx(lim_ff[ra[5]].rmin);
        OFS_RMAX: rd_mux = sx(lim_ff[ra[5]].rmax);
        OFS_VALUE: rd_mux = sx(val_ff[ra[5]]);
        default: rd_mux = '0;
      endcase
    end else begin
      unique case (ra)
        ADR_MERGE: rd_mux = {25'h0, alt_sel_ff, 1'b0, merge_ff};
        ADR_MODE: rd_mux = {30'h0, mode_ff};
        ADR_SPD_POS: rd_mux = sx(spd_pos_ff);
        ADR_SPD_NEG: rd_mux = sx(spd_neg_ff);
        ADR_STATUS: rd_mux = {30'h0, status_ff};
        ADR_MASK: rd_mux = {30'h0, mask_ff};
        ADR_RESULT: rd_mux = sx(cmd_out);
        ADR_RAMP: rd_mux = sx(ramp_speed);
        default: rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= mapped(ra) ? rd_mux : 32'h0000_0000;
      s_axi_rresp <= mapped(ra) ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // cvi_top

/* verif/cvi_src_model.sv */
// Far-side model: analog samples, measured values, digital pins and fieldbus words.
// Assumes the bench sets the live values right after a clock edge.
`timescale 1ns/100ps
module cvi_src_model
  import cvi_pkg::*;
#(
  parameter int NAI = 4,
  parameter int NDI = 8
) (
  input wire logic core_clk,
  input wire logic [DW-1:0] ana_set,
  input wire logic dig_set,
  input wire logic [DW-1:0] bus_set,
  output logic [NAI-1:0][DW-1:0] ana_in,
  output logic [NDI-1:0][DW-1:0] meas_in,
  output logic [NDI-1:0] dig_pin,
  output logic [1:0][DW-1:0] bus_cmd
);
  // Idle channels carry values far from any test level, so a wrong selector shows up.
  // The pin is not tied to the core clock, so it moves between edges.
  always @(posedge core_clk) begin
    ana_in <= {{(NAI-1){24'h5A5A5A}}, ana_set};
    meas_in <= {NDI{24'h3C3C3C}};
    bus_cmd <= {bus_set, 24'h6B6B6B};
    dig_pin <= #1.7 {{(NDI-1){1'b1}}, dig_set};
  end
endmodule // cvi_src_model

/* verif/cvi_top_chk.sv */
// Port checker for cvi_top, bound to every instance.
// Assumes one clock domain and a master that keeps AXI4-Lite ordering.
`timescale 1ns/100ps
module cvi_top_chk
  import cvi_pkg::*;
#(
  parameter int NAI = 4,
  parameter int NDI = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [NAI-1:0][DW-1:0] ana_in,
  input wire logic [NDI-1:0][DW-1:0] meas_in,
  input wire logic [NDI-1:0] dig_pin,
  input wire logic [1:0][DW-1:0] bus_cmd,
  input wire logic [DW-1:0] cmd_out,
  input wire logic [DW-1:0] ramp_speed,
  input wire logic speed_mode,
  input wire logic [1:0] cbrk,
  input wire logic irq
);
  logic [7:0] quiet_ff;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // Eight quiet cycles exceed the slowest path, the pin filter included.
  always_ff @(posedge core_clk) begin
    if (rst || !$stable(ana_in) || !$stable(meas_in) || !$stable(dig_pin)
        || !$stable(bus_cmd) || s_axi_awvalid || s_axi_wvalid) begin
      quiet_ff <= 8'h00;
    end else if (quiet_ff != 8'hFF) begin
      quiet_ff <= quiet_ff + 8'h01;
    end
  end
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  read_turn_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_turn_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  speed_zero_a:
    assert property (!speed_mode [*3] |-> ramp_speed == 24'h000000)
    else $error("ramp speed outside speed merge");
  out_steady_a:
    assert property (quiet_ff >= 8'h08 |-> $stable(cmd_out) && $stable(ramp_speed)
    && $stable(cbrk)) else $error("output moved with quiet inputs");
  irq_fall_a: assert property ($fell(irq) |-> $past(s_axi_bvalid))
    else $error("interrupt fell without a write");
  cbrk_seen_c: cover property ($rose(cbrk[0]));
  irq_seen_c: cover property ($rose(irq));
  speed_seen_c: cover property ($rose(speed_mode));
endmodule // cvi_top_chk

bind cvi_top cvi_top_chk #(.NAI(NAI), .NDI(NDI)) u_chk (
  .core_clk(core_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .ana_in(ana_in), .meas_in(meas_in), .dig_pin(dig_pin), .bus_cmd(bus_cmd),
  .cmd_out(cmd_out), .ramp_speed(ramp_speed), .speed_mode(speed_mode), .cbrk(cbrk), .irq(irq));

/* verif/cvi_top_bench.sv */
// Self-checking bench for cvi_top: register tasks, source model, answer queues.
// Assumes the checker binds itself and answers come back in request order.
`timescale 1ns/100ps
module cvi_top_bench
  import cvi_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, dig_set = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic speed_mode, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, cbrk;
  logic [31:0] s_axi_rdata;
  logic [3:0][DW-1:0] ana_in;
  logic [7:0][DW-1:0] meas_in;
  logic [7:0] dig_pin;
  logic [1:0][DW-1:0] bus_cmd;
  logic [DW-1:0] cmd_out, ramp_speed, ana_set = 24'h0, bus_set = 24'h0;
  logic [33:0] exp_q[$];
  logic [1:0] b_q[$];
  int n_mismatch = 0, check_count = 0, c2, e, m;
  logic [7:0] ra[11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h40, 8'h48, 8'h4C,
                         8'h54, 8'h20};
  int rv[11] = '{0, 500, 10000, 0, 10000, 10000, 0, 1000, 1000, 0, 0};

  cvi_src_model u_src (.core_clk(core_clk), .ana_set(ana_set), .dig_set(dig_set),
    .bus_set(bus_set), .ana_in(ana_in), .meas_in(meas_in), .dig_pin(dig_pin), .bus_cmd(bus_cmd));
  cvi_top u_dut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ana_in(ana_in), .meas_in(meas_in), .dig_pin(dig_pin),
    .bus_cmd(bus_cmd), .cmd_out(cmd_out), .ramp_speed(ramp_speed), .speed_mode(speed_mode),
    .cbrk(cbrk), .irq(irq));

  always #2.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] got, input logic [33:0] want);
    check_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic give_verdict();
    $display("%0d checks, %0d mismatches", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic lost();
    n_mismatch++;
    $display("unexpected at %0t: no answer", $time);
    give_verdict();
  endtask
  function automatic logic [33:0] ok(input int v);
    return {2'b00, v};
  endfunction
  // Answers are matched in order, so one read or write at a time keeps the queues aligned.
  always @(negedge core_clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) chk({s_axi_rresp, s_axi_rdata},
      exp_q.size() ? exp_q.pop_front() : 34'h3FFFFFFFF);
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) chk(s_axi_bresp,
      b_q.size() ? b_q.pop_front() : 2'b11);
  end
  // Ready is raised late on purpose, so the slave has to hold its answer.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    int n;
    logic [1:0] pend, got;
    b_q.push_back(er);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    pend = 2'b11;
    n = 0;
    while (pend != 2'b00 && n < 50) begin
      @(negedge core_clk);
      got = pend & {s_axi_awready === 1'b1, s_axi_wready === 1'b1};
      @(posedge core_clk);
      n++;
      pend = pend & ~got;
      if (got[1]) s_axi_awvalid <= 1'b0;
      if (got[0]) s_axi_wvalid <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
    s_axi_bready <= 1'b1;
    do begin
      @(negedge core_clk);
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    @(posedge core_clk);
    s_axi_bready <= 1'b0;
    if (n >= 50) lost();
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] want);
    int n;
    exp_q.push_back(want);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (s_axi_arready !== 1'b1 && n < 50);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b0;
    @(posedge core_clk);
    s_axi_rready <= 1'b1;
    do begin
      @(negedge core_clk);
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    @(posedge core_clk);
    s_axi_rready <= 1'b0;
    if (n >= 50) lost();
  endtask
  task automatic src(input int a, input logic d, input int b);
    @(posedge core_clk);
    ana_set <= a[DW-1:0];
    dig_set <= d;
    bus_set <= b[DW-1:0];
    repeat (10) @(posedge core_clk);
  endtask

  initial begin
    void'($urandom(82));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    foreach (ra[i]) rd(ra[i], ok(rv[i]));
    rd(8'h60, {2'b10, 32'h0});
    wr(8'h60, 32'h1, 2'b10);
    $display("reset and map test done");
    src(10000, 1'b0, 0);
    wr(8'h00, 32'h412);
    rd(8'h08, ok(20000));
    rd(8'h10, ok(20000));
    rd(8'h1C, ok(5000));
    src(10000, 1'b1, $urandom_range(9999, 100));
    wr(8'h20, 32'h1);
    rd(8'h58, ok(5000));
    rd(8'h3C, ok(0));
    for (int k = 0; k < 5; k++) begin
      m = (k == 4) ? 3 : k + 1;
      c2 = $urandom_range(9999, 100);
      if ($urandom_range(1, 0) == 1) c2 = -c2;
      src(10000, k != 4, c2);
      wr(8'h40, 32'(m + 16));
      e = (m == 1) ? 5000 + c2 : (m == 3 && k != 4) ? c2 : 5000;
      if (m == 2) e = (c2 > 0) ? 5000 * c2 / 10000 : 50000000 / -c2;
      rd(8'h58, ok(e));
      chk(cmd_out, e[DW-1:0]);
      rd(8'h3C, ok(c2));
      chk(speed_mode, m == 4);
      if (m == 4) rd(8'h5C, ok(1000 * (c2 < 0 ? -c2 : c2) / 10000));
    end
    wr(8'h40, 32'h0);
    chk(ramp_speed, 0);
    $display("merge test done");
    wr(8'h54, 32'h1);
    src(400, 1'b0, 0);
    chk(cbrk, 2'b01);
    chk(irq, 1'b1);
    src(500, 1'b0, 0);
    chk(cbrk, 2'b00);
    src(20001, 1'b0, 0);
    chk(cbrk, 2'b01);
    src(20000, 1'b0, 0);
    chk(cbrk, 2'b00);
    wr(8'h54, 32'h0);
    chk(irq, 1'b0);
    wr(8'h54, 32'h1);
    chk(irq, 1'b1);
    wr(8'h50, 32'h1);
    chk(irq, 1'b0);
    wr(8'h00, 32'h012);
    src(100, 1'b0, 0);
    chk(cbrk, 2'b00);
    $display("cable break test done");
    wr(8'h44, 32'h1);
    wr(8'h00, 32'h416);
    rd(8'h00, ok(32'h412));
    wr(8'h00, 32'h410);
    rd(8'h08, ok(10000));
    wr(8'h44, 32'h0);
    wr(8'h00, 32'h41E);
    rd(8'h00, ok(32'h410));
    wr(8'h00, 32'h002);
    src(10000, 1'b1, 0);
    rd(8'h1C, ok(0));
    wr(8'h00, 32'h084);
    rd(8'h1C, ok(10000));
    rd(8'h08, ok(1));
    src(10000, 1'b0, 0);
    rd(8'h1C, ok(0));
    $display("signal type test done");
    wr(8'h00, 32'h412);
    wr(8'h04, 32'h3E8);
    wr(8'h14, 32'h7D0);
    src(800, 1'b0, 0);
    chk(cbrk, 2'b01);
    rd(8'h1C, ok(2320));
    $display("limit write test done");
    give_verdict();
  end
endmodule // cvi_top_bench
